// [src/rtu_frame_pkg.sv]
// shared constants, types and decode helpers for the rtu slave frame decoder
// What this block does
// - frame: gap, address, function, data, check low-high, gap
// - address zero broadcasts, 1 to 247 one slave
// - response carries the query's address unchanged
// - own address is the station number setting
// - unsupported function code gets an error response
// - normal response echoes the function code
// - error response returns function code plus 80h
// - 03h reads holding registers, never broadcast
// - 06h writes one register, broadcast allowed
// - 08h is diagnostic check, never broadcast
// - 10h writes several registers, broadcast allowed
// - 46h reports last access count, never broadcast
// - frames bounded by 3.5 character idle gaps
// - no response after character or check errors
// - broadcast executes permitted functions, never responds
package rtu_frame_pkg;

   // clock rate and character framing
   localparam longint unsigned CLK_HZ = 250_000_000;
   localparam int unsigned BITS_PER_CHAR = 11;
   // interframe silence in tenths of a character time
   localparam longint unsigned SILENCE_TENTHS = 35;
   localparam int unsigned BAUD_DEFAULT = 19200;

   // address values
   localparam logic [7:0] ADDR_BCAST = 8'h00;
   // function codes
   localparam logic [7:0] FC_READ_HOLD = 8'h03;
   localparam logic [7:0] FC_WRITE_ONE = 8'h06;
   localparam logic [7:0] FC_DIAG = 8'h08;
   localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
   localparam logic [7:0] FC_ACCESS_LOG = 8'h46;
   // bit added to the function code in an error response
   localparam logic [7:0] FC_ERR_FLAG = 8'h80;
   // fifo shape
   localparam int unsigned FIFO_DEPTH = 32;

   // operation handed to the executor
   typedef enum logic [2:0] {
      OP_NONE,
      OP_READ_HOLD,
      OP_WRITE_ONE,
      OP_DIAG,
      OP_WRITE_MULTI,
      OP_ACCESS_LOG
   } op_t;

   // one received character or an end-of-frame marker
   typedef struct packed {
      logic eof;
      logic err;
      logic [7:0] data;
   } rx_word_t;

   // command issued at the end of each frame
   typedef struct packed {
      op_t op;
      logic bcast;
      logic [7:0] addr;
      logic [7:0] func;
   } cmd_t;

   // response header
   typedef struct packed {
      logic is_err;
      logic [7:0] addr;
      logic [7:0] func;
   } resp_t;

   // minimum silence in clock cycles, rounded up
   function automatic int unsigned silence_cycles(int unsigned baud);
      longint unsigned num;
      longint unsigned den;
      num = SILENCE_TENTHS * BITS_PER_CHAR * CLK_HZ;
      den = 64'd10 * baud;
      return int'((num + den - 64'd1) / den);
   endfunction

   // maps a function code onto an operation
   function automatic op_t func_op(logic [7:0] fc);
      unique case (fc)
         FC_READ_HOLD: return OP_READ_HOLD;
         FC_WRITE_ONE: return OP_WRITE_ONE;
         FC_DIAG: return OP_DIAG;
         FC_WRITE_MULTI: return OP_WRITE_MULTI;
         FC_ACCESS_LOG: return OP_ACCESS_LOG;
         default: return OP_NONE;
      endcase
   endfunction

   // only the two write functions may be broadcast
   function automatic logic bcast_ok(logic [7:0] fc);
      return (fc == FC_WRITE_ONE) || (fc == FC_WRITE_MULTI);
   endfunction

endpackage

// [src/rtu_byte_fifo.sv]
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module rtu_byte_fifo #(
   parameter int unsigned WIDTH = 10,
   parameter int unsigned DEPTH = 32
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];  // storage
   logic [AW-1:0] wr_q;  // write pointer
   logic [AW-1:0] rd_q;  // read pointer
   logic [AW:0] cnt_q;  // words held
   logic push;
   logic pop;

   assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_out = (cnt_q != '0);
   assign out_data_out = mem[rd_q];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   // storage write, no reset needed
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_q] <= in_data_in;
      end
   end

   // pointers and fill count
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// [src/rtu_slave_frame_decoder.sv]
// rtu slave frame decoder: gap framing, address match, function decode
`timescale 1ns/1ps
module rtu_slave_frame_decoder #(
   parameter int unsigned BAUD = rtu_frame_pkg::BAUD_DEFAULT,
   parameter int unsigned GAP_CYCLES = rtu_frame_pkg::silence_cycles(BAUD)
) (
   input wire logic SYS_CLK_IN,
   input wire logic RSTN_IN,
   // received characters from the serial receiver
   input wire logic RX_VALID_IN,
   output logic RX_READY_OUT,
   input wire logic [7:0] RX_DATA_IN,
   input wire logic RX_ERR_IN,
   // check code verdict for all characters so far
   input wire logic CRC_OK_IN,
   // station_number_setting
   input wire logic [7:0] STATION_IN,
   // frame body (data and check bytes) to the executor
   output logic BODY_VALID_OUT,
   output logic [7:0] BODY_OUT,
   // one command per frame
   output logic CMD_VALID_OUT,
   output rtu_frame_pkg::cmd_t CMD_OUT,
   // response header to the transmitter
   output logic RESP_VALID_OUT,
   input wire logic RESP_READY_IN,
   output rtu_frame_pkg::resp_t RESP_OUT
);

   typedef enum logic [2:0] {
      S_ADDR,
      S_FUNC,
      S_BODY,
      S_DECIDE,
      S_RESP
   } state_t;

   localparam logic [31:0] GAP_LAST = 32'(GAP_CYCLES - 1);

   // receive side
   logic [31:0] gap_cnt_q;  // idle cycles since last character
   logic gap_hit;  // silence long enough to close a frame
   logic synced_q;  // a gap has been seen since reset
   logic open_q;  // characters pushed since the last marker
   logic mark_now;  // push an end marker this cycle
   logic rx_fire;  // character accepted
   logic fifo_in_valid;
   logic fifo_in_ready;
   rtu_frame_pkg::rx_word_t fifo_in;
   // drain side
   logic fifo_out_valid;
   logic fifo_out_ready;
   rtu_frame_pkg::rx_word_t fifo_out;
   logic pop;
   state_t state_q;
   logic [7:0] addr_q;  // captured address
   logic [7:0] func_q;  // captured function code
   logic err_q;  // any character or check error
   logic [1:0] body_q;  // body bytes seen, saturating at two
   // decision terms
   logic frame_bad;
   logic is_bcast;
   logic is_mine;
   logic fc_known;

   // the gap counter saturates one short of the silence length
   assign gap_hit = (gap_cnt_q == GAP_LAST);
   assign mark_now = open_q && gap_hit;
   assign RX_READY_OUT = fifo_in_ready && !mark_now;
   assign rx_fire = RX_VALID_IN && RX_READY_OUT;

   // marker carries the check verdict; early characters are tainted
   always_comb begin
      fifo_in.eof = mark_now;
      fifo_in.err = mark_now ? !CRC_OK_IN : (RX_ERR_IN || !synced_q);
      fifo_in.data = mark_now ? 8'h00 : RX_DATA_IN;
      fifo_in_valid = mark_now || RX_VALID_IN;
   end

   // silence timer, restarted by every character
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         gap_cnt_q <= '0;
      end else if (rx_fire) begin
         gap_cnt_q <= '0;
      end else if (!gap_hit) begin
         gap_cnt_q <= gap_cnt_q + 32'd1;
      end
   end

   // framing state on the receive side
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         synced_q <= 1'b0;
         open_q <= 1'b0;
      end else begin
         if (gap_hit) begin
            synced_q <= 1'b1;
         end
         if (rx_fire) begin
            open_q <= 1'b1;
         end else if (mark_now && fifo_in_ready) begin
            open_q <= 1'b0;
         end
      end
   end

   rtu_byte_fifo #(
      .WIDTH($bits(rtu_frame_pkg::rx_word_t)),
      .DEPTH(rtu_frame_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_in(SYS_CLK_IN),
      .rstn_in(RSTN_IN),
      .in_valid_in(fifo_in_valid),
      .in_ready_out(fifo_in_ready),
      .in_data_in(fifo_in),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(fifo_out_ready),
      .out_data_out(fifo_out)
   );

   // drain only while collecting a frame; a waiting response stalls it
   assign fifo_out_ready = (state_q == S_ADDR) || (state_q == S_FUNC)
      || (state_q == S_BODY);
   assign pop = fifo_out_valid && fifo_out_ready;

   // short frames and tainted characters are bad
   assign frame_bad = err_q || (body_q != 2'd2);
   assign is_bcast = (addr_q == rtu_frame_pkg::ADDR_BCAST);
   assign is_mine = !is_bcast && (addr_q == STATION_IN);
   assign fc_known = (rtu_frame_pkg::func_op(func_q)
      != rtu_frame_pkg::OP_NONE);

   // frame collection state machine
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         state_q <= S_ADDR;
      end else begin
         unique case (state_q)
            S_ADDR: begin
               // a lone marker is an empty frame
               if (pop && !fifo_out.eof) begin
                  state_q <= S_FUNC;
               end
            end
            S_FUNC: begin
               if (pop) begin
                  state_q <= fifo_out.eof ? S_DECIDE : S_BODY;
               end
            end
            S_BODY: begin
               if (pop && fifo_out.eof) begin
                  state_q <= S_DECIDE;
               end
            end
            S_DECIDE: begin
               state_q <= (!frame_bad && is_mine) ? S_RESP : S_ADDR;
            end
            S_RESP: begin
               if (RESP_READY_IN) begin
                  state_q <= S_ADDR;
               end
            end
         endcase
      end
   end

   // header fields and error accumulation
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         addr_q <= '0;
         func_q <= '0;
         err_q <= 1'b0;
         body_q <= '0;
      end else if (pop) begin
         if (state_q == S_ADDR) begin
            addr_q <= fifo_out.data;
            err_q <= fifo_out.err;
            body_q <= '0;
         end else begin
            err_q <= err_q || fifo_out.err;
            if (state_q == S_FUNC && !fifo_out.eof) begin
               func_q <= fifo_out.data;
            end
            if (state_q == S_BODY && !fifo_out.eof && body_q != 2'd2) begin
               body_q <= body_q + 2'd1;
            end
         end
      end
   end

   // body bytes pass straight to the executor
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         BODY_VALID_OUT <= 1'b0;
         BODY_OUT <= '0;
      end else begin
         BODY_VALID_OUT <= pop && (state_q == S_BODY) && !fifo_out.eof;
         if (pop && state_q == S_BODY && !fifo_out.eof) begin
            BODY_OUT <= fifo_out.data;
         end
      end
   end

   // one command per finished frame; rejected frames get OP_NONE
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         CMD_VALID_OUT <= 1'b0;
         CMD_OUT <= '0;
      end else begin
         CMD_VALID_OUT <= (state_q == S_DECIDE);
         if (state_q == S_DECIDE) begin
            CMD_OUT.addr <= addr_q;
            CMD_OUT.func <= func_q;
            CMD_OUT.bcast <= is_bcast;
            if (frame_bad) begin
               CMD_OUT.op <= rtu_frame_pkg::OP_NONE;
            end else if (is_bcast) begin
               // reads, diagnostics and access log are dropped
               CMD_OUT.op <= rtu_frame_pkg::bcast_ok(func_q)
                  ? rtu_frame_pkg::func_op(func_q)
                  : rtu_frame_pkg::OP_NONE;
            end else if (is_mine) begin
               CMD_OUT.op <= rtu_frame_pkg::func_op(func_q);
            end else begin
               CMD_OUT.op <= rtu_frame_pkg::OP_NONE;
            end
         end
      end
   end

   // response header, held until the transmitter takes it
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         RESP_VALID_OUT <= 1'b0;
         RESP_OUT <= '0;
      end else if (state_q == S_DECIDE) begin
         // broadcast and foreign frames never answer
         RESP_VALID_OUT <= !frame_bad && is_mine;
         RESP_OUT.addr <= addr_q;
         RESP_OUT.is_err <= !fc_known;
         RESP_OUT.func <= fc_known ? func_q
            : (func_q | rtu_frame_pkg::FC_ERR_FLAG);
      end else if (RESP_VALID_OUT && RESP_READY_IN) begin
         RESP_VALID_OUT <= 1'b0;
      end
   end

   // checks

   sequence seq_decide_clean;
      state_q == S_DECIDE && !frame_bad;
   endsequence

   sequence seq_bcast_frame;
      seq_decide_clean ##0 is_bcast;
   endsequence

   sequence seq_mine_frame;
      seq_decide_clean ##0 is_mine;
   endsequence

   a_marker_after_gap: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      (fifo_in_valid && fifo_in.eof) |-> gap_cnt_q == GAP_LAST && !rx_fire)
      else $error("end marker pushed before full silence");

   a_bad_frame_quiet: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      (state_q == S_DECIDE && frame_bad) |=> CMD_VALID_OUT
      && CMD_OUT.op == rtu_frame_pkg::OP_NONE && !RESP_VALID_OUT)
      else $error("bad frame produced action or response");

   a_bcast_no_resp: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_bcast_frame |=> CMD_VALID_OUT && CMD_OUT.bcast && !RESP_VALID_OUT
      ##1 !RESP_VALID_OUT)
      else $error("broadcast frame produced a response");

   a_bcast_filter: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_bcast_frame ##0 !rtu_frame_pkg::bcast_ok(func_q)
      |=> CMD_OUT.op == rtu_frame_pkg::OP_NONE)
      else $error("forbidden broadcast function executed");

   a_bcast_write: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_bcast_frame ##0 func_q == rtu_frame_pkg::FC_WRITE_ONE
      |=> CMD_OUT.op == rtu_frame_pkg::OP_WRITE_ONE)
      else $error("broadcast single write not executed");

   a_foreign_ignored: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_decide_clean ##0 (!is_bcast && addr_q != STATION_IN)
      |=> CMD_OUT.op == rtu_frame_pkg::OP_NONE && !RESP_VALID_OUT)
      else $error("foreign address frame acted upon");

   a_resp_addr_echo: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_mine_frame |=> RESP_VALID_OUT && RESP_OUT.addr == $past(addr_q))
      else $error("response address differs from query");

   a_normal_echo: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_mine_frame ##0 fc_known |=> !RESP_OUT.is_err
      && RESP_OUT.func == CMD_OUT.func && CMD_OUT.op != rtu_frame_pkg::OP_NONE)
      else $error("normal response function code not echoed");

   a_error_code: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_mine_frame ##0 !fc_known |=> RESP_OUT.is_err
      && RESP_OUT.func == ($past(func_q) | 8'h80)
      && CMD_OUT.op == rtu_frame_pkg::OP_NONE)
      else $error("error response code wrong or operation run");

   a_read_decode: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_mine_frame ##0 func_q == rtu_frame_pkg::FC_READ_HOLD
      |=> CMD_OUT.op == rtu_frame_pkg::OP_READ_HOLD)
      else $error("read function not decoded");

   a_resp_holds: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      (RESP_VALID_OUT && !RESP_READY_IN) |=> RESP_VALID_OUT
      && $stable(RESP_OUT) && state_q == S_RESP)
      else $error("response header dropped before taken");

endmodule

// [test/rtu_master_model.sv]
// bus master model that offers query characters to the frame decoder
`timescale 1ns/1ps
module rtu_master_model #(
   parameter int GAP = 20
) (
   input wire logic clk_in,
   input wire logic ready_in,
   output logic valid_out,
   output logic [7:0] data_out,
   output logic err_out,
   output logic crc_ok_out
);
   // idle link before the first frame
   initial begin
      valid_out = 1'b0;
      data_out = 8'h00;
      err_out = 1'b0;
      crc_ok_out = 1'b1;
   end

   // sends address, function, data and check bytes back to back
   task automatic send_frame(input logic [7:0] q[$], input int bad,
                             input logic crc);
      @(posedge clk_in);
      crc_ok_out <= crc;
      // each byte held until the decoder takes it
      foreach (q[i]) begin
         valid_out <= 1'b1;
         data_out <= q[i];
         err_out <= (i == bad);
         do @(posedge clk_in); while (ready_in !== 1'b1);
      end
      valid_out <= 1'b0;
      err_out <= 1'b0;
      // released data line keeps changing during the closing gap
      repeat (GAP + 4) begin
         data_out <= ~data_out;
         @(posedge clk_in);
      end
   endtask
endmodule

// [test/rtu_slave_frame_decoder_tb.sv]
// self-checking bench for the rtu slave frame decoder
`timescale 1ns/1ps
module rtu_slave_frame_decoder_tb;
   localparam int GAP = 20; // shortened silence for simulation
   logic sys_clk, rstn, auto_ack, saw_full, rv_q;
   logic rx_valid, rx_ready, rx_err, crc_ok, body_valid;
   logic cmd_valid, resp_valid, resp_ready;
   logic [7:0] rx_data, body, station, body_last;
   rtu_frame_pkg::cmd_t cmd, cmd_q;
   rtu_frame_pkg::resp_t resp, resp_q;
   int cmd_cnt, body_cnt, cyc, error_cnt, compares;

   // free-running 250 mhz clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   rtu_slave_frame_decoder #(.GAP_CYCLES(GAP)) u_rtu_slave_frame_decoder (
      .SYS_CLK_IN(sys_clk), .RSTN_IN(rstn),
      .RX_VALID_IN(rx_valid), .RX_READY_OUT(rx_ready),
      .RX_DATA_IN(rx_data), .RX_ERR_IN(rx_err), .CRC_OK_IN(crc_ok),
      .STATION_IN(station), .BODY_VALID_OUT(body_valid),
      .BODY_OUT(body), .CMD_VALID_OUT(cmd_valid), .CMD_OUT(cmd),
      .RESP_VALID_OUT(resp_valid), .RESP_READY_IN(resp_ready),
      .RESP_OUT(resp));

   rtu_master_model #(.GAP(GAP)) u_rtu_master_model (
      .clk_in(sys_clk), .ready_in(rx_ready), .valid_out(rx_valid),
      .data_out(rx_data), .err_out(rx_err), .crc_ok_out(crc_ok));

   // captures commands, body bytes, refusals; acknowledges headers
   always @(posedge sys_clk) begin
      if (cmd_valid === 1'b1) begin
         cmd_q <= cmd;
         resp_q <= resp;
         rv_q <= resp_valid;
         cmd_cnt <= cmd_cnt + 1;
      end
      if (body_valid === 1'b1) body_cnt <= body_cnt + 1;
      if (body_valid === 1'b1) body_last <= body;
      if (rx_valid && rx_ready === 1'b0) saw_full <= 1'b1;
      resp_ready <= auto_ack && resp_valid === 1'b1 && !resp_ready;
      cyc <= cyc + 1;
      // hang guard
      if (cyc == 30000) begin
         error_cnt++;
         end_of_test();
      end
   end

   // prints the counts and the verdict
   task automatic end_of_test();
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // one comparison
   task automatic check_eq(input logic [31:0] got, exp, input string msg);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t %s got %0h exp %0h", $time, msg, got,
                  exp);
      end
   endtask

   // sends one frame and judges the command and header it yields
   task automatic do_frame(input logic [7:0] a, f, input int nd, bad,
                           input logic crc, input rtu_frame_pkg::op_t op,
                           input logic bc, rsp, er);
      logic [7:0] q[$];
      int n0;
      int b0;
      int k;
      q = {a, f};
      for (int i = 0; i < nd; i++) q.push_back(8'h30 + 8'(i));
      q.push_back(8'h5a);
      q.push_back(8'ha5);
      n0 = cmd_cnt;
      b0 = body_cnt;
      u_rtu_master_model.send_frame(q, bad, crc);
      k = 0;
      while (cmd_cnt == n0 && k < 200) begin
         @(posedge sys_clk);
         k++;
      end
      check_eq(cmd_cnt - n0, 1, "one command per frame");
      check_eq(cmd_q.op, op, "operation");
      check_eq(cmd_q.bcast, bc, "broadcast flag");
      check_eq(cmd_q.addr, a, "command address");
      check_eq(cmd_q.func, f, "command function");
      check_eq(rv_q, rsp, "response presence");
      if (rsp) begin
         check_eq(resp_q.addr, a, "header address");
         check_eq(resp_q.func, er ? (f | rtu_frame_pkg::FC_ERR_FLAG) : f,
                  "header function");
         check_eq(resp_q.is_err, er, "header error flag");
      end
      // body bytes of accepted frames reach the executor
      if (op != rtu_frame_pkg::OP_NONE) begin
         check_eq(body_cnt - b0, nd + 2, "body bytes");
         check_eq(body_last, 8'ha5, "last body byte");
      end
      k = 0;
      while (auto_ack && resp_valid === 1'b1 && k < 20) begin
         @(posedge sys_clk);
         k++;
      end
   endtask

   // first frame after reset, to a foreign station
   task automatic sync_frame();
      do_frame(8'h09, 8'h03, 2, -1, 1'b1, rtu_frame_pkg::OP_NONE, 0, 0, 0);
   endtask

   // every supported code to our own station
   task automatic own_codes();
      logic [7:0] fc[5] = '{8'h03, 8'h06, 8'h08, 8'h10, 8'h46};
      rtu_frame_pkg::op_t op[5] = '{rtu_frame_pkg::OP_READ_HOLD,
         rtu_frame_pkg::OP_WRITE_ONE, rtu_frame_pkg::OP_DIAG,
         rtu_frame_pkg::OP_WRITE_MULTI, rtu_frame_pkg::OP_ACCESS_LOG};
      for (int i = 0; i < 5; i++) begin
         do_frame(8'h05, fc[i], 2, -1, 1'b1, op[i], 0, 1, 0);
      end
   endtask

   // unsupported codes get an error header
   task automatic bad_codes();
      logic [7:0] fc[3] = '{8'h01, 8'h07, 8'hff};
      for (int i = 0; i < 3; i++) begin
         do_frame(8'h05, fc[i], 2, -1, 1'b1, rtu_frame_pkg::OP_NONE,
                  0, 1, 1);
      end
   endtask

   // broadcast of each code: only writes execute, nothing answers
   task automatic bcast_codes();
      logic [7:0] fc[5] = '{8'h03, 8'h06, 8'h08, 8'h10, 8'h46};
      rtu_frame_pkg::op_t op[5] = '{rtu_frame_pkg::OP_NONE,
         rtu_frame_pkg::OP_WRITE_ONE, rtu_frame_pkg::OP_NONE,
         rtu_frame_pkg::OP_WRITE_MULTI, rtu_frame_pkg::OP_NONE};
      for (int i = 0; i < 5; i++) begin
         do_frame(8'h00, fc[i], 2, -1, 1'b1, op[i], 1, 0, 0);
      end
   endtask

   // character error and check mismatch stay silent
   task automatic corrupt_frames();
      do_frame(8'h05, 8'h03, 2, 3, 1'b1, rtu_frame_pkg::OP_NONE, 0, 0, 0);
      do_frame(8'h05, 8'h03, 2, -1, 1'b0, rtu_frame_pkg::OP_NONE, 0, 0, 0);
   endtask

   // highest station number, then the old one is foreign
   task automatic top_station();
      @(posedge sys_clk);
      station <= 8'hf7;
      do_frame(8'hf7, 8'h06, 2, -1, 1'b1, rtu_frame_pkg::OP_WRITE_ONE,
               0, 1, 0);
      do_frame(8'h05, 8'h06, 2, -1, 1'b1, rtu_frame_pkg::OP_NONE, 0, 0, 0);
      @(posedge sys_clk);
      station <= 8'h05;
   endtask

   // pending header stalls the fifo until it refuses, then drains
   task automatic fifo_full();
      int k;
      auto_ack <= 1'b0;
      do_frame(8'h05, 8'h03, 2, -1, 1'b1, rtu_frame_pkg::OP_READ_HOLD,
               0, 1, 0);
      @(posedge sys_clk);
      saw_full <= 1'b0;
      fork
         do_frame(8'h05, 8'h10, 36, -1, 1'b1,
                  rtu_frame_pkg::OP_WRITE_MULTI, 0, 1, 0);
         begin
            k = 0;
            while (saw_full !== 1'b1 && k < 80) begin
               @(posedge sys_clk);
               k++;
            end
            check_eq(saw_full, 1'b1, "fifo refusal");
            auto_ack <= 1'b1;
         end
      join
      check_eq(rx_ready, 1'b1, "fifo drained");
   endtask

   // reset, then the scenarios in turn
   initial begin
      rstn = 1'b0;
      auto_ack = 1'b1;
      saw_full = 1'b0;
      resp_ready = 1'b0;
      station = 8'h05;
      cmd_cnt = 0;
      body_cnt = 0;
      cyc = 0;
      error_cnt = 0;
      compares = 0;
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      sync_frame();
      own_codes();
      bad_codes();
      bcast_codes();
      corrupt_frames();
      top_station();
      fifo_full();
      end_of_test();
   end
endmodule
